/* File: swb_consts.vh */
// Function
// - Every external store passes through this buffer
// - Four entries of 64-bit address plus data
// - Line write-back fills buffer, core keeps running
// - Uncached and write-through stores accepted without waiting
// - Full buffer stalls further stores
// - Lone buffered write drains to bus
// - Lone core read issues external read
// - Read beats write when both contend
// - Address match with entry blocks read priority
// - Uncached read waits behind uncached writes
// - Condition low when occupied, high empty
// - Barrier holds core until stores complete
`ifndef SWB_CONSTS_VH
`define SWB_CONSTS_VH

`define SWB_AW 64
`define SWB_DW 64
`define SWB_DEPTH 3'h4
`define SWB_PTR_W 2
`define SWB_CNT_W 3
`define SWB_OQ_DEPTH 2'h2
`define SWB_COND_EMPTY 1'b1
`define SWB_COND_BUSY 1'b0

`endif

/* File: swb_mem.v */
`timescale 1ns/1ps
`default_nettype none
`include "swb_consts.vh"

// ----------------------------------------
// Entry data store, registered read
// ----------------------------------------
module swb_mem (
	input wire clk,
	input wire we,
	input wire [`SWB_PTR_W-1:0] wa,
	input wire [`SWB_DW-1:0] wd,
	input wire [`SWB_PTR_W-1:0] ra,
	output reg [`SWB_DW-1:0] q_reg
);

reg [`SWB_DW-1:0] mem [0:3];

always @(posedge clk) begin
	if (we) begin
		mem[wa] <= wd;
	end
	if (we && (wa == ra)) begin
		q_reg <= wd;
	end else begin
		q_reg <= mem[ra];
	end
end

endmodule
`default_nettype wire

/* File: swb_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "swb_consts.vh"

module swb_top (
	input wire ref_clk,
	input wire rst,
	input wire st_valid,
	input wire [`SWB_AW-1:0] st_addr,
	input wire [`SWB_DW-1:0] st_data,
	input wire st_uncached,
	output reg st_ready_reg,
	input wire rd_req,
	input wire [`SWB_AW-1:0] rd_addr,
	input wire rd_uncached,
	output reg rd_ack_reg,
	input wire sync_req,
	output reg sync_hold_reg,
	output reg cop_cond_reg,
	output reg bus_valid_reg,
	output reg bus_write_reg,
	output reg [`SWB_AW-1:0] bus_addr_reg,
	output reg [`SWB_DW-1:0] bus_data_reg,
	input wire bus_ready
);

// ----------------------------------------
// Entry bookkeeping
// ----------------------------------------
function swb_live;
	input [1:0] idx;
	input [1:0] rp;
	input [2:0] cnt;
	reg [1:0] off;
	begin
		off = idx - rp;
		swb_live = ({1'b0, off} < cnt);
	end
endfunction

reg [`SWB_PTR_W-1:0] wr_ptr_reg;
reg [`SWB_PTR_W-1:0] wr_ptr_next;
reg [`SWB_PTR_W-1:0] rd_ptr_reg;
reg [`SWB_PTR_W-1:0] rd_ptr_next;
reg [`SWB_CNT_W-1:0] count_reg;
reg [`SWB_CNT_W-1:0] count_next;
reg [`SWB_AW-1:0] ent_addr_reg [0:3];
reg [3:0] ent_unc_reg;
wire [`SWB_DW-1:0] head_data;
wire [3:0] hit_vec;
wire [3:0] unc_vec;

// Whole line write-back and single stores share one path
wire st_take = st_valid & st_ready_reg;

genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_scan
		localparam [1:0] slot_idx = gi;
		assign hit_vec[gi] = swb_live(slot_idx, rd_ptr_reg, count_reg) &
			(ent_addr_reg[gi] == rd_addr);
		assign unc_vec[gi] = swb_live(slot_idx, rd_ptr_reg, count_reg) &
			ent_unc_reg[gi];
	end
endgenerate

swb_mem u_mem (
	.clk(ref_clk),
	.we(st_take),
	.wa(wr_ptr_reg),
	.wd(st_data),
	.ra(rd_ptr_next),
	.q_reg(head_data)
);

// ----------------------------------------
// Output queue, two entries to the bus
// ----------------------------------------
reg oq_v1_reg;
reg oq_w1_reg;
reg [`SWB_AW-1:0] oq_a1_reg;
reg [`SWB_DW-1:0] oq_d1_reg;
reg [1:0] oq_cnt_reg;
wire oq_pop = bus_valid_reg & bus_ready;
wire oq_space = (oq_cnt_reg != `SWB_OQ_DEPTH) | oq_pop;

// ----------------------------------------
// Arbitration
// ----------------------------------------
wire has_w = (count_reg != 3'h0);
wire has_r = rd_req & ~rd_ack_reg;
wire rd_blocked = (|hit_vec) | (rd_uncached & (|unc_vec));
reg grant_rd;
reg grant_wr;
reg push_v;
reg push_w;
reg [`SWB_AW-1:0] push_a;
reg [`SWB_DW-1:0] push_d;

always @* begin
	grant_rd = 1'b0;
	grant_wr = 1'b0;
	if (oq_space) begin
		if (has_r && !rd_blocked) begin
			grant_rd = 1'b1;
		end else if (has_w) begin
			grant_wr = 1'b1;
		end
	end
	push_v = grant_rd | grant_wr;
	push_w = grant_wr;
	if (grant_wr) begin
		push_a = ent_addr_reg[rd_ptr_reg];
		push_d = head_data;
	end else begin
		push_a = rd_addr;
		push_d = {`SWB_DW{1'b0}};
	end
end

// ----------------------------------------
// Pointer and count update
// ----------------------------------------
always @* begin
	wr_ptr_next = wr_ptr_reg;
	rd_ptr_next = rd_ptr_reg;
	count_next = count_reg;
	if (st_take) begin
		wr_ptr_next = wr_ptr_reg + 2'h1;
	end
	if (grant_wr) begin
		rd_ptr_next = rd_ptr_reg + 2'h1;
	end
	case ({st_take, grant_wr})
		2'b10: begin
			count_next = count_reg + 3'h1;
		end
		2'b01: begin
			count_next = count_reg - 3'h1;
		end
		default: begin
			count_next = count_reg;
		end
	endcase
end

// Writes still on their way out
wire oq_wr_left = (bus_valid_reg & bus_write_reg & ~oq_pop) |
	(oq_v1_reg & oq_w1_reg) | (push_v & push_w);
wire drained = (count_next == 3'h0) & ~oq_wr_left;

integer i;

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		wr_ptr_reg <= 2'h0;
		rd_ptr_reg <= 2'h0;
		count_reg <= 3'h0;
		ent_unc_reg <= 4'h0;
		for (i = 0; i < 4; i = i + 1) begin
			ent_addr_reg[i] <= {`SWB_AW{1'b0}};
		end
	end else begin
		wr_ptr_reg <= wr_ptr_next;
		rd_ptr_reg <= rd_ptr_next;
		count_reg <= count_next;
		if (st_take) begin
			ent_addr_reg[wr_ptr_reg] <= st_addr;
			ent_unc_reg[wr_ptr_reg] <= st_uncached;
		end
	end
end

// ----------------------------------------
// Core handshake outputs
// ----------------------------------------
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		st_ready_reg <= 1'b0;
		rd_ack_reg <= 1'b0;
	end else begin
		st_ready_reg <= (count_next != `SWB_DEPTH);
		rd_ack_reg <= grant_rd;
	end
end

// ----------------------------------------
// Barrier tracking
// ----------------------------------------
localparam [1:0] BAR_IDLE = 2'b01;
localparam [1:0] BAR_WAIT = 2'b10;
reg [1:0] bar_state_reg;
reg [1:0] bar_state_next;

always @* begin
	bar_state_next = bar_state_reg;
	case (bar_state_reg)
		BAR_IDLE: begin
			if (sync_req && !drained) begin
				bar_state_next = BAR_WAIT;
			end
		end
		BAR_WAIT: begin
			if (drained) begin
				bar_state_next = BAR_IDLE;
			end
		end
		default: begin
			bar_state_next = BAR_IDLE;
		end
	endcase
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		bar_state_reg <= BAR_IDLE;
		sync_hold_reg <= 1'b0;
	end else begin
		bar_state_reg <= bar_state_next;
		sync_hold_reg <= (bar_state_next == BAR_WAIT);
	end
end

// ----------------------------------------
// Empty condition
// ----------------------------------------
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		cop_cond_reg <= `SWB_COND_EMPTY;
	end else begin
		if (count_next == 3'h0) begin
			cop_cond_reg <= `SWB_COND_EMPTY;
		end else begin
			cop_cond_reg <= `SWB_COND_BUSY;
		end
	end
end

// ----------------------------------------
// Output queue registers
// ----------------------------------------
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		oq_cnt_reg <= 2'h0;
		bus_valid_reg <= 1'b0;
		bus_write_reg <= 1'b0;
		bus_addr_reg <= {`SWB_AW{1'b0}};
		bus_data_reg <= {`SWB_DW{1'b0}};
		oq_v1_reg <= 1'b0;
		oq_w1_reg <= 1'b0;
		oq_a1_reg <= {`SWB_AW{1'b0}};
		oq_d1_reg <= {`SWB_DW{1'b0}};
	end else begin
		case ({oq_pop, push_v})
			2'b11: begin
				if (oq_cnt_reg == 2'h2) begin
					bus_write_reg <= oq_w1_reg;
					bus_addr_reg <= oq_a1_reg;
					bus_data_reg <= oq_d1_reg;
					oq_w1_reg <= push_w;
					oq_a1_reg <= push_a;
					oq_d1_reg <= push_d;
				end else begin
					bus_write_reg <= push_w;
					bus_addr_reg <= push_a;
					bus_data_reg <= push_d;
				end
			end
			2'b10: begin
				bus_valid_reg <= oq_v1_reg;
				bus_write_reg <= oq_w1_reg;
				bus_addr_reg <= oq_a1_reg;
				bus_data_reg <= oq_d1_reg;
				oq_v1_reg <= 1'b0;
				oq_w1_reg <= 1'b0;
				oq_cnt_reg <= oq_cnt_reg - 2'h1;
			end
			2'b01: begin
				if (oq_cnt_reg == 2'h0) begin
					bus_valid_reg <= 1'b1;
					bus_write_reg <= push_w;
					bus_addr_reg <= push_a;
					bus_data_reg <= push_d;
				end else begin
					oq_v1_reg <= 1'b1;
					oq_w1_reg <= push_w;
					oq_a1_reg <= push_a;
					oq_d1_reg <= push_d;
				end
				oq_cnt_reg <= oq_cnt_reg + 2'h1;
			end
			default: begin
				oq_cnt_reg <= oq_cnt_reg;
			end
		endcase
	end
end

endmodule
`default_nettype wire

/* File: swb_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module swb_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic st_valid,
	input wire logic st_ready_reg,
	input wire logic rd_req,
	input wire logic rd_ack_reg,
	input wire logic sync_req,
	input wire logic sync_hold_reg,
	input wire logic cop_cond_reg,
	input wire logic bus_valid_reg,
	input wire logic bus_write_reg,
	input wire logic bus_ready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_st;
		st_valid && st_ready_reg && cop_cond_reg && !bus_valid_reg && !rd_req;
	endsequence
	sequence s_wr;
		##[1:4] (bus_valid_reg && bus_write_reg);
	endsequence
	chk_store_drain: assert property (s_st |-> s_wr)
		else $error("store not drained");
	chk_ack_read: assert property (rd_ack_reg && $past(!bus_valid_reg)
		|-> bus_valid_reg && !bus_write_reg)
		else $error("ack without bus read");
	chk_ack_pulse: assert property (rd_ack_reg |=> !rd_ack_reg)
		else $error("ack longer than one cycle");
	chk_full_busy: assert property ($fell(st_ready_reg) |-> !cop_cond_reg)
		else $error("stall while empty");
	chk_store_busy: assert property (st_valid && st_ready_reg |=> !cop_cond_reg)
		else $error("condition high after store");
	chk_bus_hold: assert property (bus_valid_reg && !bus_ready
		|=> bus_valid_reg && $stable(bus_write_reg))
		else $error("bus request dropped");
	chk_sync_hold: assert property (sync_req && !cop_cond_reg |=> sync_hold_reg)
		else $error("barrier not held");
	chk_hold_drop: assert property ($fell(sync_hold_reg) |-> cop_cond_reg)
		else $error("barrier released early");
endmodule
bind swb_top swb_chk chk_u (.*);
`default_nettype wire

/* File: swb_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// System bus slave
// ----
module swb_bus_model (
	input wire logic ref_clk,
	input wire logic bus_valid_reg,
	input wire logic bus_write_reg,
	input wire logic [63:0] bus_addr_reg,
	input wire logic [63:0] bus_data_reg,
	input wire logic stall,
	output logic bus_ready
);
	logic [128:0] seen[$];
	assign bus_ready = !stall;
	always @(posedge ref_clk) begin
		if (bus_valid_reg && bus_ready)
			seen.push_back({bus_write_reg, bus_addr_reg, bus_data_reg});
	end
endmodule
`default_nettype wire

/* File: store_write_buffer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
// ----
// Bench top
// ----
module store_write_buffer_tb;
	logic ref_clk = 0, rst = 1, st_valid = 0, rd_req = 0, stall = 0;
	logic st_uncached = 0, rd_uncached = 0, sync_req = 0;
	logic [63:0] st_addr = 0, rd_addr = 0;
	wire logic st_ready_reg, rd_ack_reg, sync_hold_reg, cop_cond_reg;
	wire logic bus_valid_reg, bus_write_reg, bus_ready;
	wire logic [63:0] bus_addr_reg, bus_data_reg;
	int bad_count = 0, samples_checked = 0;
	always #5 ref_clk = ~ref_clk;
	swb_top dut_u (.*, .st_data(~st_addr));
	swb_bus_model bus_u (.*);
	task automatic store(input logic [63:0] a);
		@(negedge ref_clk);
		st_valid = 1;
		st_addr = a;
		while (st_ready_reg !== 1'h1) @(negedge ref_clk);
		@(negedge ref_clk);
		st_valid = 0;
	endtask
	task automatic rd(input logic [63:0] a);
		rd_addr = a;
		rd_req = 1;
		do @(negedge ref_clk); while (rd_ack_reg !== 1'h1);
		rd_req = 0;
	endtask
	task automatic t_read;
		rd(64'h2000);
		`CHK("bus write", 1'h0, bus_write_reg)
		`CHK("bus addr", 64'h2000, bus_addr_reg)
		`CHK("bus valid", 1'h1, bus_valid_reg)
		@(negedge ref_clk);
		`CHK("ack pulse", 1'h0, rd_ack_reg)
		`CHK("read seen", {1'h0, 64'h2000, 64'h0}, bus_u.seen[0])
		$display("t_read done");
	endtask
	task automatic t_fill;
		bus_u.seen.delete();
		stall = 1;
		for (int i = 0; i < 6; i++) store(64'h100 + i * 8);
		`CHK("st_ready full", 1'h0, st_ready_reg)
		`CHK("cond busy", 1'h0, cop_cond_reg)
		stall = 0;
		repeat (12) @(negedge ref_clk);
		`CHK("cond empty", 1'h1, cop_cond_reg)
		for (int i = 0; i < 6; i++)
			`CHK("order", {1'h1, 64'h100 + i * 8, ~(64'h100 + i * 8)}, bus_u.seen[i])
		$display("t_fill done");
	endtask
	task automatic t_hazard;
		for (int k = 0; k < 2; k++) begin
			bus_u.seen.delete();
			st_uncached = k[0];
			rd_uncached = k[0];
			store(64'h300);
			rd(k ? 64'h380 : 64'h300);
			repeat (4) @(negedge ref_clk);
			`CHK("write first", {1'h1, 64'h300, ~64'h300}, bus_u.seen[0])
			`CHK("read second", {1'h0, k ? 64'h380 : 64'h300, 64'h0}, bus_u.seen[1])
		end
		$display("t_hazard done");
	endtask
	task automatic t_sync;
		bus_u.seen.delete();
		stall = 1;
		store(64'h400);
		sync_req = 1;
		@(negedge ref_clk);
		sync_req = 0;
		`CHK("hold", 1'h1, sync_hold_reg)
		stall = 0;
		while (sync_hold_reg !== 1'h0) @(negedge ref_clk);
		`CHK("stores done", 1, bus_u.seen.size())
		`CHK("sync store", {1'h1, 64'h400, ~64'h400}, bus_u.seen[0])
		$display("t_sync done");
	endtask
	task automatic complete_run;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 0;
		repeat (2) @(negedge ref_clk);
		t_read();
		t_fill();
		t_hazard();
		t_sync();
		complete_run();
	end
endmodule
`default_nettype wire
